/* src/rrn_consts.svh */
// Opcode patterns, field positions and timing constants of the return/rotate/negate executor
`ifndef RRN_CONSTS_SVH
`define RRN_CONSTS_SVH

`define RRN_OP_NOP         16'h0000
`define RRN_OP_RETURN      16'h0002
`define RRN_OP_RETEI       16'h0005
`define RRN_RETURN_WITH_LITERAL_HI       8'hB6
`define RRN_NEGATE_WORKING_HI7       7'h16
`define RRN_ROTATE_LEFT_VIA_CARRY_HI7       7'h0D
`define RRN_SEL_BIT        8
`define RRN_GID_BIT        4
`define RRN_CARRY_BIT      0
`define RRN_DC_BIT         1
`define RRN_ZERO_BIT       2
`define RRN_OV_BIT         3
`define RRN_STATUS_RESET   8'h00
`define RRN_CORE_STA_RESET 8'h10
`define RRN_W_RESET        8'h00
`define RRN_PHASES         4

`endif

/* src/rrn_decode.sv */
// Opcode classifier for the return/rotate/negate instruction group
`timescale 1ns/10ps
`include "rrn_consts.svh"

module rrn_decode (
	input  wire logic [15:0]      opcode,
	output rrn_pkg::rrn_op_e      op_kind
);
	// Exact matches first; field-carrying patterns compare only their fixed bits
	always_comb begin
		if (opcode == `RRN_OP_NOP) begin
			op_kind = rrn_pkg::OP_NOP;                      // RULE3
		end else if (opcode == `RRN_OP_RETEI) begin
			op_kind = rrn_pkg::OP_RETEI;                    // RULE4
		end else if (opcode == `RRN_OP_RETURN) begin
			op_kind = rrn_pkg::OP_RETURN;                   // RULE10
		end else if (opcode[15:8] == `RRN_RETURN_WITH_LITERAL_HI) begin
			op_kind = rrn_pkg::OP_RETURN_WITH_LITERAL;                    // RULE7
		end else if (opcode[15:9] == `RRN_NEGATE_WORKING_HI7) begin
			op_kind = rrn_pkg::OP_NEGATE_WORKING;                     // RULE1
		end else if (opcode[15:9] == `RRN_ROTATE_LEFT_VIA_CARRY_HI7) begin
			op_kind = rrn_pkg::OP_ROTATE_LEFT_VIA_CARRY;                     // RULE11
		end else begin
			op_kind = rrn_pkg::OP_NONE;
		end
	end
endmodule

/* src/rrn_exec.sv */
// Executor for negate, no-op, returns and rotate-left-through-carry, in four quarter phases
// Behaviour
// RULE1 - Negate forms two's complement of working; select 0 writes working and f, 1 f only
// RULE2 - Negate writes file register and optional working register in the fourth phase; the file write strobe stands in the next decode phase
// RULE3 - No-op is all zeros, one cycle, changes nothing but advances the program counter
// RULE4 - Return-enable-interrupts decodes from 0x0005, takes two cycles, second idle
// RULE5 - Return-enable-interrupts pops stack into program counter in first cycle's fourth phase; the pop strobe stands in the second cycle's decode phase
// RULE6 - Return-enable-interrupts clears interrupt disable bit 4 in third phase, nothing else
// RULE7 - Return-with-literal decodes from upper byte 0xB6 and loads low byte into working
// RULE8 - Return-with-literal pops stack into PC, two cycles, second idle, flags untouched
// RULE9 - Every return leaves the program-counter high latch unchanged
// RULE10 - Plain return 0x0002 pops stack into PC in two cycles, no flag or interrupt change
// RULE11 - Rotate left via carry: old carry to bit 0, old bit 7 to carry, only carry
// RULE12 - Rotate destination 0 writes working, 1 writes file register, one cycle
// RULE13 - Each instruction cycle runs decode, read, process, write phases in order
`timescale 1ns/10ps
`include "rrn_consts.svh"

module rrn_exec #(
	parameter int ADDR_W = 8,
	parameter int PC_W   = 16
) (
	input  wire logic              sys_clk,
	input  wire logic              reset,
	input  wire logic              clk_en,
	input  wire logic [15:0]       instr,
	input  wire logic              instr_valid,
	input  wire logic [7:0]        file_rd_data,
	input  wire logic [PC_W-1:0]   top_of_stack_entry,
	output logic                   instr_take,
	output logic [1:0]             phase,
	output logic [ADDR_W-1:0]      file_addr,
	output logic                   file_rd_en,
	output logic                   file_wr_en,
	output logic [7:0]             file_wr_data,
	output logic                   stack_pop,
	output logic                   pc_load,
	output logic [PC_W-1:0]        pc_load_value,
	output logic                   pc_advance,
	output logic                   unknown_op,
	output logic [7:0]             working_register,
	output logic [7:0]             alu_status,
	output logic [7:0]             core_status_register
);
	////////////////////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		rrn_pkg::rrn_phase_e    ph;
		rrn_pkg::rrn_op_e       op;
		logic [15:0]            ir;
		logic                   idle_cycle;
		logic [7:0]             operand;
		logic [7:0]             result;
		logic [7:0]             w;
		logic [7:0]             st;
		logic [7:0]             csr;
		logic                   f_wr;
		logic [7:0]             f_data;
		logic                   pop;
		logic                   pcl;
		logic [PC_W-1:0]        pcv;
		logic                   adv;
	} rrn_state_s;

	rrn_state_s          state_reg;
	rrn_state_s          state_next;
	rrn_pkg::rrn_op_e    dec_op;
	logic [8:0]          neg_sum;
	logic [4:0]          neg_low;

	// Decode is combinational on the offered opcode; only the decode phase latches its class
	rrn_decode rrn_decode_i (
		.opcode  (instr),
		.op_kind (dec_op)
	);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Arithmetic: negate is ~W + 1, carry/DC taken from the adder as on an add of ~W and 1
	// The adders read the live working register, so a negate always sees the value left
	// by the previous instruction's write phase, never a half-updated one.
	assign neg_sum = {1'b0, ~state_reg.w} + 9'h001;
	assign neg_low = {1'b0, ~state_reg.w[3:0]} + 5'h01;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Next-state: one phase per enabled clock; strobes last exactly one phase
	always_comb begin
		state_next        = state_reg;
		state_next.f_wr   = 1'b0;
		state_next.pop    = 1'b0;
		state_next.pcl    = 1'b0;
		state_next.adv    = 1'b0;
		case (state_reg.ph)
			rrn_pkg::PH_DECODE: begin
				// An idle second cycle of a return ignores the fetch stream
				if (state_reg.idle_cycle) begin
					state_next.op = rrn_pkg::OP_NOP;                // RULE4 RULE8 RULE10
				end else if (instr_valid) begin
					state_next.op = dec_op;
					state_next.ir = instr;
				end else begin
					state_next.op = rrn_pkg::OP_NOP;
				end
				state_next.ph = rrn_pkg::PH_READ;                   // RULE13
			end
			rrn_pkg::PH_READ: begin
				case (state_reg.op)
					rrn_pkg::OP_ROTATE_LEFT_VIA_CARRY:  state_next.operand = file_rd_data;
					rrn_pkg::OP_RETURN_WITH_LITERAL: state_next.operand = state_reg.ir[7:0];  // RULE7
					default:           state_next.operand = state_reg.operand;
				endcase
				state_next.ph = rrn_pkg::PH_PROCESS;                // RULE13
			end
			rrn_pkg::PH_PROCESS: begin
				case (state_reg.op)
					rrn_pkg::OP_NEGATE_WORKING: begin
						state_next.result = neg_sum[7:0];                  // RULE1
						state_next.st[`RRN_CARRY_BIT] = neg_sum[8];
						state_next.st[`RRN_DC_BIT]    = neg_low[4];
						state_next.st[`RRN_ZERO_BIT]  = (neg_sum[7:0] == 8'h00);
						// Overflow only for 0x80: negating the most negative value
						state_next.st[`RRN_OV_BIT]    = state_reg.w[7] & neg_sum[7];
					end
					rrn_pkg::OP_ROTATE_LEFT_VIA_CARRY: begin
						state_next.result = {state_reg.operand[6:0],
							state_reg.st[`RRN_CARRY_BIT]};                   // RULE11
						state_next.st[`RRN_CARRY_BIT] = state_reg.operand[7];  // RULE11
					end
					rrn_pkg::OP_RETEI: begin
						state_next.csr[`RRN_GID_BIT] = 1'b0;                   // RULE6
					end
					default: begin
						state_next.result = state_reg.result;
					end
				endcase
				state_next.ph = rrn_pkg::PH_WRITE;                  // RULE13
			end
			rrn_pkg::PH_WRITE: begin
				state_next.idle_cycle = 1'b0;
				state_next.adv        = 1'b1;                       // RULE3
				case (state_reg.op)
					rrn_pkg::OP_NEGATE_WORKING: begin
						state_next.f_wr   = 1'b1;                          // RULE2
						state_next.f_data = state_reg.result;
						if (!state_reg.ir[`RRN_SEL_BIT]) begin
							state_next.w = state_reg.result;               // RULE1 RULE2
						end
					end
					rrn_pkg::OP_ROTATE_LEFT_VIA_CARRY: begin
						if (state_reg.ir[`RRN_SEL_BIT]) begin
							state_next.f_wr   = 1'b1;                      // RULE12
							state_next.f_data = state_reg.result;
						end else begin
							state_next.w = state_reg.result;               // RULE12
						end
					end
					rrn_pkg::OP_RETEI, rrn_pkg::OP_RETURN, rrn_pkg::OP_RETURN_WITH_LITERAL: begin
						// Pop replaces the advance; the high latch is never touched here
						state_next.adv        = 1'b0;
						state_next.pop        = 1'b1;                      // RULE5 RULE8 RULE10
						state_next.pcl        = 1'b1;                      // RULE9
						state_next.pcv        = top_of_stack_entry;        // RULE5
						state_next.idle_cycle = 1'b1;                      // RULE4 RULE8
						if (state_reg.op == rrn_pkg::OP_RETURN_WITH_LITERAL) begin
							state_next.w = state_reg.operand;              // RULE7
						end
					end
					rrn_pkg::OP_NOP: begin
						// Second cycle of a return is its own stall: no advance
						state_next.adv = ~state_reg.idle_cycle;            // RULE3
					end
					default: begin
						state_next.adv = 1'b1;
					end
				endcase
				state_next.ph = rrn_pkg::PH_DECODE;                 // RULE13
			end
			default: begin
				state_next.ph = rrn_pkg::PH_DECODE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// State register; clock enable low freezes everything including the strobes
	// Reset wins over the clock enable so a frozen core can still be brought to a known state
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_reg            <= '0;
			state_reg.ph         <= rrn_pkg::PH_DECODE;
			state_reg.op         <= rrn_pkg::OP_NONE;
			state_reg.w          <= `RRN_W_RESET;
			state_reg.st         <= `RRN_STATUS_RESET;
			state_reg.csr        <= `RRN_CORE_STA_RESET;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Outputs
	// Write, pop, load and advance strobes are registered: they stand during the decode phase after the write phase,
	// and the partner must act on them at the next enabled edge. This costs one phase of
	// latency but keeps those strobes glitch free.
	assign instr_take           = clk_en & (state_reg.ph == rrn_pkg::PH_DECODE)
		& instr_valid & ~state_reg.idle_cycle;
	assign phase                = state_reg.ph;
	assign file_addr            = state_reg.ir[ADDR_W-1:0];
	assign file_rd_en           = (state_reg.ph == rrn_pkg::PH_READ)
		& (state_reg.op == rrn_pkg::OP_ROTATE_LEFT_VIA_CARRY);
	assign file_wr_en           = state_reg.f_wr;
	assign file_wr_data         = state_reg.f_data;
	assign stack_pop            = state_reg.pop;
	assign pc_load              = state_reg.pcl;
	assign pc_load_value        = state_reg.pcv;
	assign pc_advance           = state_reg.adv;
	assign unknown_op           = (state_reg.op == rrn_pkg::OP_NONE)
		& (state_reg.ph != rrn_pkg::PH_DECODE);
	assign working_register     = state_reg.w;
	assign alu_status           = state_reg.st;
	assign core_status_register = state_reg.csr;
endmodule

/* src/rrn_pkg.sv */
// Types shared by the return/rotate/negate executor
package rrn_pkg;
	typedef enum logic [1:0] {
		PH_DECODE,
		PH_READ,
		PH_PROCESS,
		PH_WRITE
	} rrn_phase_e;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_NOP,
		OP_NEGATE_WORKING,
		OP_RETEI,
		OP_RETURN_WITH_LITERAL,
		OP_RETURN,
		OP_ROTATE_LEFT_VIA_CARRY
	} rrn_op_e;
endpackage

/* verif/return_rotate_negate_exec_tb_top.sv */
// Self-checking bench for the return/rotate/negate executor
`timescale 1ns/10ps
module return_rotate_negate_exec_tb_top;
	logic        sys_clk     = 1'b0;
	logic        reset       = 1'b1;
	logic        clk_en      = 1'b1;
	logic        instr_valid = 1'b0;
	logic [15:0] instr       = 16'h0000;
	logic [15:0] top_of_stack_entry, pc_load_value;
	logic [7:0]  file_rd_data, file_addr, file_wr_data, working_register, alu_status, csr;
	logic [1:0]  phase;
	logic        instr_take, file_rd_en, file_wr_en, stack_pop, pc_load, pc_advance;
	logic        unknown_op;
	logic        unknown_seen = 1'b0;
	int          error_cnt  = 0;
	int          num_checks = 0;

	rrn_exec rrn_exec_i (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .instr(instr),
		.instr_valid(instr_valid), .file_rd_data(file_rd_data),
		.top_of_stack_entry(top_of_stack_entry),
		.instr_take(instr_take), .phase(phase), .file_addr(file_addr), .file_rd_en(file_rd_en),
		.file_wr_en(file_wr_en), .file_wr_data(file_wr_data), .stack_pop(stack_pop),
		.pc_load(pc_load), .pc_load_value(pc_load_value), .pc_advance(pc_advance),
		.unknown_op(unknown_op),
		.working_register(working_register), .alu_status(alu_status), .core_status_register(csr));
	// Unknown flag only stands mid-instruction, so keep what it showed in the process phase
	always @(negedge sys_clk) begin
		if (phase == 2'h2) unknown_seen <= unknown_op;
	end
	rrn_partner rrn_partner_i (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
		.file_addr(file_addr), .file_rd_en(file_rd_en), .file_wr_en(file_wr_en),
		.file_wr_data(file_wr_data), .stack_pop(stack_pop), .pc_load(pc_load),
		.pc_load_value(pc_load_value), .pc_advance(pc_advance), .file_rd_data(file_rd_data),
		.top_of_stack_entry(top_of_stack_entry));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk8(input logic [7:0] act, input logic [7:0] exp);
		num_checks++;
		if (act !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, act, exp);
		end
	endtask
	task automatic chk16(input logic [15:0] act, input logic [15:0] exp);
		num_checks++;
		if (act !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, act, exp);
		end
	endtask
	// Offers an opcode, optionally freezes after the take, stops where results land
	task automatic issue(input logic [15:0] op, input int stall);
		int n;
		n = 0;
		@(posedge sys_clk);
		instr <= op;
		instr_valid <= 1'b1;
		@(negedge sys_clk);
		while (instr_take !== 1'b1 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		@(posedge sys_clk);
		instr_valid <= 1'b0;
		if (stall > 0) clk_en <= 1'b0;
		repeat (stall) @(posedge sys_clk);
		clk_en <= 1'b1;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_return_with_literal();
		issue(16'hB63A, 0);
		chk8(working_register, 8'h3A);
		chk16(pc_load_value, 16'h0345);
		chk8({stack_pop, pc_load, pc_advance, alu_status[4:0]}, 8'hC0);
		$display("return_with_literal test done");
	endtask
	task automatic t_negate_working();
		issue(16'h2C10, 0);
		chk8(working_register, 8'hC6);
		chk8({file_wr_en, file_addr[6:0]}, 8'h90);
		chk8(file_wr_data, 8'hC6);
		issue(16'h2D11, 0);
		chk8(working_register, 8'hC6);
		chk8(file_wr_data, 8'h3A);
		$display("negate_working test done");
	endtask
	task automatic t_rotate_left_via_carry();
		issue(16'h1B20, 3);
		chk8(file_wr_data, 8'hCC);
		chk8({file_wr_en, alu_status[6:0]}, 8'h81);
		issue(16'h1A20, 0);
		chk8(working_register, 8'h99);
		chk8({file_wr_en, alu_status[6:0]}, 8'h01);
		$display("rotate_left_via_carry test done");
	endtask
	task automatic t_nop();
		issue(16'h0000, 0);
		chk8({pc_advance, file_wr_en, pc_load, alu_status[4:0]}, 8'h81);
		chk8(working_register, 8'h99);
		chk8({7'h00, unknown_seen}, 8'h00);
		$display("nop test done");
	endtask
	task automatic t_unknown();
		issue(16'hFFFF, 0);
		chk8({unknown_seen, pc_advance, file_wr_en, pc_load, alu_status[3:0]}, 8'hC1);
		chk8(working_register, 8'h99);
		$display("unknown test done");
	endtask
	task automatic t_return();
		issue(16'h0002, 0);
		chk16(pc_load_value, 16'h0A10);
		chk8(csr, 8'h10);
		$display("return test done");
	endtask
	task automatic t_return_enable_interrupts();
		issue(16'h0005, 0);
		chk16(pc_load_value, 16'h1FFE);
		chk8(csr, 8'h00);
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk16(rrn_partner_i.pc, 16'h1FFE);
		$display("return_enable_interrupts test done");
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	// Watchdog: the whole sequence needs under a hundred cycles
	initial begin
		repeat (2000) @(posedge sys_clk);
		error_cnt++;
		wrap_up();
	end
	initial begin
		rrn_partner_i.stack[2] = 16'h0345;
		rrn_partner_i.stack[1] = 16'h0A10;
		rrn_partner_i.stack[0] = 16'h1FFE;
		rrn_partner_i.mem[8'h20] = 8'hE6;
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		t_return_with_literal();
		t_negate_working();
		t_rotate_left_via_carry();
		t_nop();
		t_unknown();
		t_return();
		t_return_enable_interrupts();
		wrap_up();
	end
endmodule

/* verif/rrn_exec_props.sv */
// Concurrent checks on the executor's ports
`timescale 1ns/10ps
module rrn_exec_props #(
	parameter int ADDR_W = 8,
	parameter int PC_W   = 16
) (
	input wire logic            sys_clk,
	input wire logic            reset,
	input wire logic            clk_en,
	input wire logic [PC_W-1:0] top_of_stack_entry,
	input wire logic            instr_take,
	input wire logic [1:0]      phase,
	input wire logic            file_rd_en,
	input wire logic            file_wr_en,
	input wire logic            stack_pop,
	input wire logic            pc_load,
	input wire logic [PC_W-1:0] pc_load_value,
	input wire logic            pc_advance,
	input wire logic [7:0]      alu_status,
	input wire logic [7:0]      core_status_register
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////////////////////
	a_phase_step: assert property (clk_en && !reset |=> phase == $past(phase) + 2'h1)
		else $error("phase did not step");
	a_take_decode: assert property (instr_take |-> phase == 2'h0)
		else $error("opcode taken outside decode phase");
	a_read_phase: assert property (file_rd_en |-> phase == 2'h1)
		else $error("file read outside read phase");
	a_write_pulse: assert property (file_wr_en |-> phase == 2'h0 ##1 !file_wr_en)
		else $error("file write misplaced or too long");
	a_pop_value: assert property (stack_pop |->
		pc_load && pc_load_value == $past(top_of_stack_entry))
		else $error("pop did not load stack top");
	// Idle second cycle: no advance and no new opcode for a full four phases
	a_idle_cycle: assert property (pc_load |-> (!pc_advance && !instr_take) [*4])
		else $error("return second cycle not idle");
	a_ret_flags: assert property (pc_load |-> alu_status == $past(alu_status, 4))
		else $error("return changed flags");
	a_gid_clear: assert property ($fell(core_status_register[4]) |-> phase == 2'h3)
		else $error("interrupt disable cleared in wrong phase");
	a_adv_once: assert property (pc_advance |-> phase == 2'h0 ##1 !pc_advance)
		else $error("program counter advance misplaced");
endmodule

bind rrn_exec rrn_exec_props #(.ADDR_W(ADDR_W), .PC_W(PC_W)) rrn_exec_props_i (
	.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .top_of_stack_entry(top_of_stack_entry),
	.instr_take(instr_take), .phase(phase), .file_rd_en(file_rd_en), .file_wr_en(file_wr_en),
	.stack_pop(stack_pop), .pc_load(pc_load), .pc_load_value(pc_load_value),
	.pc_advance(pc_advance), .alu_status(alu_status), .core_status_register(core_status_register));

/* verif/rrn_partner.sv */
// Behavioural program counter, return stack and file memory facing the executor
`timescale 1ns/10ps
module rrn_partner (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        clk_en,
	input  wire logic [7:0]  file_addr,
	input  wire logic        file_rd_en,
	input  wire logic        file_wr_en,
	input  wire logic [7:0]  file_wr_data,
	input  wire logic        stack_pop,
	input  wire logic        pc_load,
	input  wire logic [15:0] pc_load_value,
	input  wire logic        pc_advance,
	output logic      [7:0]  file_rd_data,
	output logic      [15:0] top_of_stack_entry
);
	logic [7:0]  mem [256];
	logic [15:0] stack [4];
	logic [1:0]  sp    = 2'h3;
	logic [15:0] pc    = 16'h0000;
	logic [7:0]  noise = 8'h5A;
	// Unread data toggles each cycle so a mistimed sample cannot match by luck
	assign file_rd_data = file_rd_en ? mem[file_addr] : noise;
	assign top_of_stack_entry = stack[sp - 2'h1];
	// Strobes count only on enabled edges, as the executor holds them while frozen
	always @(posedge sys_clk) begin
		noise <= ~noise;
		if (reset) begin
			pc <= 16'h0000;
		end else if (clk_en) begin
			if (file_wr_en) mem[file_addr] <= file_wr_data;
			if (stack_pop) sp <= sp - 2'h1;
			if (pc_load) pc <= pc_load_value;
			else if (pc_advance) pc <= pc + 16'h0001;
		end
	end
endmodule
